// *** inc/phyr_pkg.sv ***
package phyr_pkg;
    // Management register indices and the fixed PHY address
    localparam logic [4:0]  PHY_ADDR       = 5'h10;
    localparam logic [4:0]  REG_ID_TWO     = 5'h03;
    localparam logic [4:0]  REG_ADVERTISE  = 5'h04;
    localparam logic [4:0]  REG_PARTNER    = 5'h05;
    localparam logic [4:0]  REG_EXPANSION  = 5'h06;

    // Reset values
    localparam logic [15:0] ADV_RESET      = 16'h01E1;
    localparam logic [15:0] PARTNER_RESET  = 16'h0000;
    localparam logic [15:0] EXP_RESET      = 16'h0000;
    localparam logic [4:0]  SELECTOR_8023  = 5'h01;

    // Advertisement field positions
    localparam int ADV_EXTRA_PAGE_BIT      = 15;
    localparam int ADV_ACK_BIT             = 14;
    localparam int ADV_FAULT_BIT           = 13;
    localparam int ADV_PAUSE_BIT           = 10;
    localparam int ADV_FOUR_PAIR_BIT       = 9;
    localparam int ADV_FAST_FULL_BIT       = 8;
    localparam int ADV_FAST_HALF_BIT       = 7;
    localparam int ADV_SLOW_FULL_BIT       = 6;
    localparam int ADV_SLOW_HALF_BIT       = 5;
    // Writable advertisement bits: 13, 10, 8:5, 4:0
    localparam logic [15:0] ADV_WRITE_MASK = 16'h25FF;
    // Partner ability keeps everything except reserved 12:11
    localparam logic [15:0] PARTNER_MASK   = 16'hE7FF;

    // Expansion field positions
    localparam int EXP_PAR_FAULT_BIT       = 4;
    localparam int EXP_PARTNER_PAGE_BIT    = 3;
    localparam int EXP_LOCAL_PAGE_BIT      = 2;
    localparam int EXP_PAGE_RX_BIT         = 1;
    localparam int EXP_PARTNER_AN_BIT      = 0;

    // Serial management frame field lengths minus one (last bit count) and opcodes
    localparam logic [3:0]  OP_BITS        = 4'h1;
    localparam logic [3:0]  ADDR_BITS      = 4'h4;
    localparam logic [3:0]  TURN_BITS      = 4'h1;
    localparam logic [3:0]  DATA_BITS      = 4'hF;
    localparam logic [1:0]  OP_READ        = 2'h2;
    localparam logic [1:0]  OP_WRITE       = 2'h1;
endpackage

// *** design/phyr_mdio_slave.sv ***
`timescale 1ns/10ps
module phyr_mdio_slave #(
    parameter logic [4:0] PHY_ADDR = phyr_pkg::PHY_ADDR
) (
    input  wire logic        clk,       // System clock
    input  wire logic        rst_n,     // Synchronous reset, active low
    input  wire logic        mdc,       // Management clock, sampled
    input  wire logic        mdio_in,   // Management data pin level
    output logic             mdio_out,  // Management data drive value
    output logic             mdio_oe,   // High while driving the data pin
    output logic             rd_req,    // One-cycle read strobe
    output logic             wr_req,    // One-cycle write strobe
    output logic [4:0]       reg_addr,  // Register index of the frame
    output logic [15:0]      wr_data,   // Write data
    input  wire logic [15:0] rd_data    // Read data, captured on rd_req
);
    typedef enum logic [6:0] {
        ST_IDLE  = 7'b0000001,
        ST_START = 7'b0000010,
        ST_OP    = 7'b0000100,
        ST_PHY   = 7'b0001000,
        ST_REG   = 7'b0010000,
        ST_TURN  = 7'b0100000,
        ST_DATA  = 7'b1000000
    } phyr_mdio_e;

    phyr_mdio_e  state;
    logic        mdc_prev;
    logic        last_bit;
    logic        is_read;
    logic        hit;
    logic [3:0]  cnt;
    logic [15:0] shreg;

    wire         rise      = mdc & ~mdc_prev;
    wire [4:0]   field5    = {shreg[3:0], mdio_in};
    wire [1:0]   field2    = {shreg[0], mdio_in};
    wire         read_hit  = is_read & hit;

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            state    <= ST_IDLE;
            // High so a management clock idling high gives no false edge at release
            mdc_prev <= 1'b1;
            last_bit <= 1'b0;
            is_read  <= 1'b0;
            hit      <= 1'b0;
            cnt      <= 4'h0;
            shreg    <= 16'h0000;
            mdio_out <= 1'b0;
            mdio_oe  <= 1'b0;
            rd_req   <= 1'b0;
            wr_req   <= 1'b0;
            reg_addr <= 5'h00;
            wr_data  <= 16'h0000;
        end else begin
            mdc_prev <= mdc;
            rd_req   <= 1'b0;
            wr_req   <= 1'b0;
            // Capture before the bank clears its latched bits
            if (rd_req) begin
                shreg <= rd_data;
            end
            if (rise) begin
                last_bit <= mdio_in;
                cnt      <= cnt + 4'h1;
                if (!(state inside {ST_TURN, ST_DATA})) begin
                    shreg <= {shreg[14:0], mdio_in};
                end
                case (state)
                    ST_IDLE: begin
                        cnt <= 4'h0;
                        if (last_bit && !mdio_in) begin
                            state <= ST_START;
                        end
                    end
                    ST_START: begin
                        cnt   <= 4'h0;
                        state <= mdio_in ? ST_OP : ST_IDLE;
                    end
                    ST_OP: begin
                        if (cnt == phyr_pkg::OP_BITS) begin
                            cnt     <= 4'h0;
                            is_read <= (field2 == phyr_pkg::OP_READ);
                            state   <= (field2 == phyr_pkg::OP_READ || field2 == phyr_pkg::OP_WRITE) ?
                                       ST_PHY : ST_IDLE;
                        end
                    end
                    ST_PHY: begin
                        if (cnt == phyr_pkg::ADDR_BITS) begin
                            cnt   <= 4'h0;
                            hit   <= (field5 == PHY_ADDR);
                            state <= ST_REG;
                        end
                    end
                    ST_REG: begin
                        if (cnt == phyr_pkg::ADDR_BITS) begin
                            cnt      <= 4'h0;
                            reg_addr <= field5;
                            rd_req   <= read_hit;
                            state    <= ST_TURN;
                        end
                    end
                    ST_TURN: begin
                        if (cnt == 4'h0) begin
                            mdio_oe  <= read_hit;
                            mdio_out <= 1'b0;
                        end else begin
                            cnt      <= 4'h0;
                            mdio_out <= read_hit & shreg[15];
                            if (read_hit) begin
                                shreg <= {shreg[14:0], 1'b0};
                            end
                            state <= ST_DATA;
                        end
                    end
                    ST_DATA: begin
                        if (read_hit) begin
                            mdio_out <= shreg[15];
                            shreg    <= {shreg[14:0], 1'b0};
                        end else begin
                            shreg <= {shreg[14:0], mdio_in};
                        end
                        if (cnt == phyr_pkg::DATA_BITS) begin
                            mdio_oe  <= 1'b0;
                            mdio_out <= 1'b0;
                            wr_data  <= {shreg[14:0], mdio_in};
                            wr_req   <= hit & ~is_read;
                            state    <= ST_IDLE;
                        end
                    end
                    default: begin
                        state <= ST_IDLE;
                    end
                endcase
            end
        end
    end
endmodule // phyr_mdio_slave

// *** design/phyr_autoneg_regs.sv ***
`timescale 1ns/10ps
module phyr_autoneg_regs #(
    parameter logic [5:0] OUI_TAIL = 6'h2A,  // Arbitrary identity value
    parameter logic [5:0] MODEL    = 6'h05,  // Arbitrary identity value
    parameter logic [3:0] REVISION = 4'h1    // Arbitrary identity value
) (
    input  wire logic        clk,               // System clock, 25 MHz
    input  wire logic        rst_n,             // Synchronous reset, active low
    input  wire logic        mdc,               // Management clock from the station
    input  wire logic        mdio_in,           // Management data pin level
    output logic             mdio_out,          // Management data drive value
    output logic             mdio_oe,           // High while driving management data
    input  wire logic        ack_sent,          // Level: partner data acknowledged
    input  wire logic        base_page_valid,   // Pulse: valid base page received
    input  wire logic [15:0] base_page_word,    // Received base page word
    input  wire logic        parallel_fault,    // Pulse: parallel detection fault
    input  wire logic        partner_an_level,  // Level: partner runs auto-negotiation
    output logic [15:0]      adv_word           // Advertised base page to the engine
);
    logic        rd_req;
    logic        wr_req;
    logic [4:0]  reg_addr;
    logic [15:0] wr_data;
    logic [15:0] rd_data;
    logic [15:0] adv_store;
    logic        ack_seen;
    logic [15:0] partner;
    logic        parallel_detection_error;
    logic        partner_extra_page_capable;
    logic        new_page_received;
    logic        partner_autoneg_capable;

    phyr_mdio_slave #(
        .PHY_ADDR (phyr_pkg::PHY_ADDR)
    ) u_mdio (
        .clk      (clk),
        .rst_n    (rst_n),
        .mdc      (mdc),
        .mdio_in  (mdio_in),
        .mdio_out (mdio_out),
        .mdio_oe  (mdio_oe),
        .rd_req   (rd_req),
        .wr_req   (wr_req),
        .reg_addr (reg_addr),
        .wr_data  (wr_data),
        .rd_data  (rd_data)
    );

    function automatic logic addr_is(input logic [4:0] addr, input logic [4:0] index);
        addr_is = (addr == index);
    endfunction

    wire adv_write   = wr_req & addr_is(reg_addr, phyr_pkg::REG_ADVERTISE);
    wire exp_read    = rd_req & addr_is(reg_addr, phyr_pkg::REG_EXPANSION);

    // Read-only bits are built here, so writes can never reach them
    wire [15:0] id_two_value = {OUI_TAIL, MODEL, REVISION};
    wire [15:0] adv_value    = {1'b0, ack_seen, adv_store[13:0]};
    wire [15:0] exp_value    = {11'h000, parallel_detection_error, partner_extra_page_capable,
                                1'b0, new_page_received, partner_autoneg_capable};

    assign rd_data = addr_is(reg_addr, phyr_pkg::REG_ID_TWO)    ? id_two_value :
                     addr_is(reg_addr, phyr_pkg::REG_ADVERTISE) ? adv_value    :
                     addr_is(reg_addr, phyr_pkg::REG_PARTNER)   ? partner      :
                     addr_is(reg_addr, phyr_pkg::REG_EXPANSION) ? exp_value    : 16'h0000;

    // Only the documented writable fields take the write; 15, 14, 12:11 and 9 stay zero
    wire [15:0] next_adv = adv_write ? (wr_data & phyr_pkg::ADV_WRITE_MASK) : adv_store;

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            adv_store <= phyr_pkg::ADV_RESET;
            ack_seen  <= 1'b0;
        end else begin
            adv_store <= next_adv;
            ack_seen  <= ack_sent;
        end
    end

    assign adv_word = adv_value;

    // Partner word is only replaced by a fresh base page; reserved bits dropped
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            partner <= phyr_pkg::PARTNER_RESET;
        end else if (base_page_valid) begin
            partner <= base_page_word & phyr_pkg::PARTNER_MASK;
        end
    end

    // Set wins over clear-on-read so an event in the read cycle is not lost
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            parallel_detection_error   <= 1'b0;
            new_page_received          <= 1'b0;
            partner_extra_page_capable <= 1'b0;
            partner_autoneg_capable    <= 1'b0;
        end else begin
            parallel_detection_error <= parallel_fault | (parallel_detection_error & ~exp_read);
            new_page_received        <= base_page_valid | (new_page_received & ~exp_read);
            if (base_page_valid) begin
                partner_extra_page_capable <= base_page_word[15];
            end
            partner_autoneg_capable <= partner_an_level;
        end
    end

    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);

    sequence s_exp_read;
        exp_read;
    endsequence

    sequence s_no_event;
        !base_page_valid && !parallel_fault;
    endsequence

    chk_adv_fixed_zero: assert property (adv_word[15] == 1'b0 && adv_word[9] == 1'b0 && adv_word[12:11] == 2'b00)
        else $error("Fixed advertisement bits not zero");

    chk_adv_ack_follow: assert property (ack_sent |=> adv_word[14])
        else $error("Acknowledge bit did not follow");

    chk_adv_write_take: assert property (adv_write |=> adv_word[13] == $past(wr_data[13])
                                         && adv_word[10] == $past(wr_data[10])
                                         && adv_word[8:0] == $past(wr_data[8:0]))
        else $error("Advertisement write not taken");

    chk_adv_reset_val: assert property ($rose(rst_n) |-> adv_store == phyr_pkg::ADV_RESET)
        else $error("Advertisement reset value wrong");

    chk_adv_hold_val: assert property (!adv_write |=> adv_store == $past(adv_store))
        else $error("Advertisement changed without write");

    chk_exp_reserved: assert property (exp_value[15:5] == 11'h000 && exp_value[2] == 1'b0)
        else $error("Expansion fixed bits not zero");

    chk_page_rx_set: assert property (base_page_valid |=> new_page_received
                                      && partner == ($past(base_page_word) & phyr_pkg::PARTNER_MASK))
        else $error("Base page not loaded");

    chk_latch_hold: assert property (new_page_received && !exp_read && !base_page_valid |=> new_page_received)
        else $error("Page flag dropped without read");

    chk_latch_clear: assert property (s_exp_read ##0 s_no_event |=> !new_page_received && !parallel_detection_error)
        else $error("Latched bits not cleared by read");

    chk_fault_latch: assert property (parallel_fault |=> parallel_detection_error [*1] ##0
                                      exp_value[4])
        else $error("Parallel fault not latched");

    chk_id_constant: assert property (rd_req && addr_is(reg_addr, phyr_pkg::REG_ID_TWO) |->
                                      rd_data == {OUI_TAIL, MODEL, REVISION})
        else $error("Identifier read wrong");

    chk_partner_stable: assert property (!base_page_valid |=> $stable(partner))
        else $error("Partner word changed without page");

    chk_an_follow: assert property (1'b1 |=> exp_value[0] == $past(partner_an_level))
        else $error("Partner negotiation bit did not follow");

    chk_extra_page_load: assert property (base_page_valid |=> exp_value[3] == partner[15])
        else $error("Partner extra page bit not loaded");

    chk_partner_reserved: assert property (partner[12:11] == 2'b00)
        else $error("Partner reserved bits not zero");

    chk_selector_reset: assert property ($rose(rst_n) |-> adv_word[4:0] == phyr_pkg::SELECTOR_8023)
        else $error("Selector reset value wrong");

    chk_status_reset: assert property ($rose(rst_n) |-> partner == phyr_pkg::PARTNER_RESET
                                       && exp_value == phyr_pkg::EXP_RESET)
        else $error("Partner or expansion reset value wrong");
endmodule // phyr_autoneg_regs

// *** dv/phyr_station_model.sv ***
`timescale 1ns/10ps
module phyr_station_model #(
    parameter int HALF = 7  // Clocks per management clock half period, keeps mdc under 2.5 MHz
) (
    input  wire logic clk,       // System clock
    input  wire logic mdio_out,  // Value driven by the slave
    input  wire logic mdio_oe,   // Slave drive enable
    output logic      mdc,       // Management clock
    output logic      mdio_in    // Resolved data pin level
);
    logic drv;

    // Pin has a pull-up, so a released or silent line reads as one
    assign mdio_in = mdio_oe ? mdio_out : drv;

    initial begin
        mdc = 1'b0;
        drv = 1'b1;
    end

    // Entered at a clock edge; bits change on mdc low, the slave samples on mdc rise
    task automatic frame(input logic [1:0] op, input logic [4:0] phy, input logic [4:0] ra,
                         input logic [15:0] wd, output logic [15:0] rd);
        logic [33:0] bits;
        logic        is_rd;
        is_rd = (op == phyr_pkg::OP_READ);
        bits  = {2'b11, 2'b01, op, phy, ra, is_rd ? 2'b11 : 2'b10, is_rd ? 16'hFFFF : wd};
        rd    = 16'h0000;
        for (int i = 33; i >= -1; i--) begin
            #1 mdc = 1'b0;
            drv = (i >= 0) ? bits[i] : 1'b1;
            repeat (HALF) @(posedge clk);
            #1 if (i >= 0 && i < 16) rd[i] = mdio_in;
            mdc = 1'b1;
            repeat (HALF) @(posedge clk);
        end
    endtask
endmodule // phyr_station_model

// *** dv/tb.sv ***
`timescale 1ns/10ps
module tb;
    localparam logic [5:0]  ID_OUI   = 6'h15;  // Arbitrary identity value
    localparam logic [5:0]  ID_MODEL = 6'h2C;  // Arbitrary identity value
    localparam logic [3:0]  ID_REV   = 4'h9;   // Arbitrary identity value
    localparam logic [15:0] ID_WORD  = {ID_OUI, ID_MODEL, ID_REV};

    logic        clk, rst_n, mdc, mdio_in, mdio_out, mdio_oe;
    logic        ack_sent, base_page_valid, parallel_fault, partner_an_level;
    logic [15:0] base_page_word, adv_word, rd;
    int          mismatches, samples_checked, cycles;

    phyr_autoneg_regs #(.OUI_TAIL(ID_OUI), .MODEL(ID_MODEL), .REVISION(ID_REV)) dut (
        .clk(clk), .rst_n(rst_n), .mdc(mdc), .mdio_in(mdio_in), .mdio_out(mdio_out),
        .mdio_oe(mdio_oe), .ack_sent(ack_sent), .base_page_valid(base_page_valid),
        .base_page_word(base_page_word), .parallel_fault(parallel_fault),
        .partner_an_level(partner_an_level), .adv_word(adv_word));

    phyr_station_model station (.clk(clk), .mdio_out(mdio_out), .mdio_oe(mdio_oe),
        .mdc(mdc), .mdio_in(mdio_in));

    initial clk = 1'b0;
    always #20 clk = ~clk;

    task automatic end_of_test();
        if (mismatches == 0 && samples_checked > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask

    // Frames take about 500 clocks each; the ceiling leaves ample margin
    always @(posedge clk) begin
        cycles++;
        if (cycles == 30000) begin
            mismatches++;
            end_of_test();
        end
    end

    task automatic check16(input logic [15:0] got, input logic [15:0] exp);
        samples_checked++;
        if (got !== exp) begin
            mismatches++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic rd_reg(input logic [4:0] ra, input logic [15:0] exp);
        station.frame(phyr_pkg::OP_READ, phyr_pkg::PHY_ADDR, ra, 16'h0000, rd);
        check16(rd, exp);
    endtask

    task automatic wr_reg(input logic [4:0] phy, input logic [4:0] ra, input logic [15:0] wd);
        logic [15:0] unused;
        station.frame(phyr_pkg::OP_WRITE, phy, ra, wd, unused);
    endtask

    task automatic do_reset();
        @(posedge clk);
        #1 rst_n = 1'b0;
        repeat (4) @(posedge clk);
        #1 rst_n = 1'b1;
        repeat (2) @(posedge clk);
    endtask

    task automatic events(input logic valid, input logic [15:0] word, input logic fault);
        @(posedge clk);
        #1 base_page_valid = valid;
        base_page_word = word;
        parallel_fault = fault;
        @(posedge clk);
        #1 base_page_valid = 1'b0;
        parallel_fault = 1'b0;
        @(posedge clk);
    endtask

    task automatic check_resets();
        rd_reg(phyr_pkg::REG_ID_TWO, ID_WORD);
        rd_reg(phyr_pkg::REG_ADVERTISE, 16'h01E1);
        check16(adv_word, 16'h01E1);
        rd_reg(phyr_pkg::REG_PARTNER, 16'h0000);
        rd_reg(phyr_pkg::REG_EXPANSION, 16'h0000);
    endtask

    initial begin
        rst_n = 1'b0;
        ack_sent = 1'b0;
        base_page_valid = 1'b0;
        base_page_word = 16'h0000;
        parallel_fault = 1'b0;
        partner_an_level = 1'b0;
        mismatches = 0;
        samples_checked = 0;
        cycles = 0;
        do_reset();
        check_resets();
        // Reserved bits are written as zero, every other bit as one
        wr_reg(phyr_pkg::PHY_ADDR, phyr_pkg::REG_ADVERTISE, 16'hE7FF);
        rd_reg(phyr_pkg::REG_ADVERTISE, 16'h25FF);
        check16(adv_word, 16'h25FF);
        wr_reg(phyr_pkg::PHY_ADDR, phyr_pkg::REG_ADVERTISE, 16'h0000);
        rd_reg(phyr_pkg::REG_ADVERTISE, 16'h0000);
        wr_reg(phyr_pkg::PHY_ADDR + 5'h01, phyr_pkg::REG_ADVERTISE, 16'h0021);
        rd_reg(phyr_pkg::REG_ADVERTISE, 16'h0000);
        station.frame(phyr_pkg::OP_READ, phyr_pkg::PHY_ADDR + 5'h01, phyr_pkg::REG_ADVERTISE, 16'h0000, rd);
        check16(rd, 16'hFFFF);
        wr_reg(phyr_pkg::PHY_ADDR, phyr_pkg::REG_ID_TWO, ~ID_WORD);
        rd_reg(phyr_pkg::REG_ID_TWO, ID_WORD);
        rd_reg(5'h1F, 16'h0000);
        #1 ack_sent = 1'b1;
        partner_an_level = 1'b1;
        wr_reg(phyr_pkg::PHY_ADDR, phyr_pkg::REG_ADVERTISE, 16'h2400);
        rd_reg(phyr_pkg::REG_ADVERTISE, 16'h6400);
        check16(adv_word, 16'h6400);
        events(1'b1, 16'hFFFF, 1'b1);
        rd_reg(phyr_pkg::REG_PARTNER, 16'hE7FF);
        rd_reg(phyr_pkg::REG_EXPANSION, 16'h001B);
        rd_reg(phyr_pkg::REG_EXPANSION, 16'h0009);
        events(1'b1, 16'h01A1, 1'b0);
        rd_reg(phyr_pkg::REG_PARTNER, 16'h01A1);
        rd_reg(phyr_pkg::REG_EXPANSION, 16'h0003);
        events(1'b1, 16'h1E21, 1'b0);
        rd_reg(phyr_pkg::REG_PARTNER, 16'h0621);
        events(1'b0, 16'hFFFF, 1'b1);
        rd_reg(phyr_pkg::REG_PARTNER, 16'h0621);
        rd_reg(phyr_pkg::REG_EXPANSION, 16'h0013);
        #1 partner_an_level = 1'b0;
        ack_sent = 1'b0;
        rd_reg(phyr_pkg::REG_EXPANSION, 16'h0000);
        events(1'b1, 16'hFFFF, 1'b1);
        // Latched flags still pending must be wiped by a reset in mid-run
        do_reset();
        check_resets();
        end_of_test();
    end
endmodule // tb
